// ===== tcpc_pkg.sv
// Package of constants and types for the timer channel pin control block.
package tcpc_pkg;
   localparam int                NCH            = 2;
   localparam logic [7:0]        ADDR_STATUS    = 8'h00;
   localparam logic [7:0]        ADDR_COUNT     = 8'h04;
   localparam logic [7:0]        ADDR_MODULO    = 8'h08;
   localparam logic [7:0]        ADDR_CH0_CTRL  = 8'h0C;
   localparam logic [7:0]        ADDR_CH0_VAL   = 8'h10;
   localparam logic [7:0]        ADDR_CH1_CTRL  = 8'h14;
   localparam logic [7:0]        ADDR_CH1_VAL   = 8'h18;
   localparam logic [1:0]        RESP_OKAY      = 2'h0;
   localparam logic [1:0]        RESP_SLVERR    = 2'h2;
   localparam logic [15:0]       MODULO_RESET   = 16'hFFFF;
   localparam logic [7:0]        CTRL_RESET     = 8'h00;
   localparam int                SYNC_STAGES    = 2;
   // Channel control byte layout.
   localparam int                BIT_MAX        = 0;
   localparam int                BIT_TOV        = 1;
   localparam int                BIT_ELS_LO     = 2;
   localparam int                BIT_ELS_HI     = 3;
   localparam int                BIT_MS_LO      = 4;
   localparam int                BIT_MS_HI      = 5;
   localparam int                BIT_CAP_FLAG   = 7;
   // Status register bits.
   localparam int                BIT_STOP       = 5;
   localparam int                BIT_RESET_CNT  = 4;
   localparam int                BIT_OVF_FLAG   = 7;

   typedef struct packed {
      logic ms_hi;
      logic ms_lo;
      logic els_hi;
      logic els_lo;
      logic tov;
      logic max_duty;
   } tcpc_cfg_s;
endpackage : tcpc_pkg

// ===== tcpc_channel.sv
// One timer channel: capture, compare and pin drive.
`timescale 1ns/1ps
module tcpc_channel #(
   parameter bit BUFFER_OK = 1'b0
) (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire tcpc_pkg::tcpc_cfg_s cfg,
   input  wire logic [15:0]        count,
   input  wire logic               count_en,
   input  wire logic               ovf,
   input  wire logic [15:0]        cmp_val,
   input  wire logic               pin_sync,
   input  wire logic               cfg_wr,
   output logic                    cap_evt,
   output logic                    pin_out,
   output logic                    pin_oe
);
   logic out_q;
   logic prev_q;
   logic max_act_q;
   logic connected;
   logic capture;
   logic compare;
   logic match;
   logic rise;
   logic fall;
   logic preset_lvl;
   logic cmp_lvl;

   assign connected  = cfg.els_hi | cfg.els_lo;
   assign capture    = connected & ~cfg.ms_hi & ~cfg.ms_lo;
   assign compare    = connected & (cfg.ms_lo | (cfg.ms_hi & BUFFER_OK));
   assign preset_lvl = ~cfg.ms_lo;
   assign match      = count_en & (count == cmp_val);
   assign rise       = pin_sync & ~prev_q;
   assign fall       = ~pin_sync & prev_q;
   assign cap_evt    = capture & ((cfg.els_lo & ~cfg.els_hi & rise) |
                                  (cfg.els_hi & ~cfg.els_lo & fall) |
                                  (cfg.els_hi & cfg.els_lo & (rise | fall)));
   assign cmp_lvl    = ({cfg.els_hi, cfg.els_lo} == 2'b01) ? ~out_q :
                       cfg.els_lo;
   assign pin_out    = (compare && max_act_q) ? 1'b1 : out_q;
   assign pin_oe     = compare;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_q     <= 1'b0;
         prev_q    <= 1'b0;
         max_act_q <= 1'b0;
      end else begin
         prev_q <= pin_sync;
         if (!connected) begin
            out_q <= preset_lvl;
         end else if (compare && ovf && cfg.tov) begin
            out_q <= ~out_q;
         end else if (compare && match) begin
            out_q <= cmp_lvl;
         end
         if (ovf) begin
            max_act_q <= cfg.tov & cfg.max_duty;
         end
      end
   end

   pin_preset_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !connected |=> out_q == $past(preset_lvl))
      else $error("preset level not applied");
   tov_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (compare && ovf && cfg.tov && connected && !cfg_wr) |=> out_q != $past(out_q))
      else $error("overflow toggle lost");
   cap_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cap_evt |-> capture && pin_sync != prev_q)
      else $error("capture without edge");
   gp_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !connected |-> !pin_oe)
      else $error("pin driven while released");
   max_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !ovf |=> max_act_q == $past(max_act_q))
      else $error("max duty changed mid period");
endmodule : tcpc_channel

// ===== tcpc_top.sv
// Two-channel timer with AXI4-Lite registers and per-channel pin control.
`timescale 1ns/1ps
module tcpc_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        break_active,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [1:0]  chan_pin_in,
   output logic [1:0]       chan_pin_out,
   output logic [1:0]       chan_pin_oe
);
   localparam int N = tcpc_pkg::NCH;

   logic [15:0] count_q;
   logic [15:0] modulo_q;
   logic [7:0]  status_q;
   logic [7:0]  ctrl_q   [N];
   logic [15:0] val_q    [N];
   logic [15:0] shadow_q [N];
   logic [N-1:0] sync1_q;
   logic [N-1:0] sync2_q;
   logic [N-1:0] cap_evt;
   logic [N-1:0] cfg_wr;
   logic        aw_q;
   logic        w_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic        count_en;
   logic        ovf;
   logic        do_wr;
   logic        wr_ok;
   logic [31:0] rd_mux;
   logic        rd_ok;
   logic        buffered;
   logic        buf_sel_q;
   logic [15:0] eff_val  [N];
   tcpc_pkg::tcpc_cfg_s cfg [N];

   assign count_en = ~break_active & ~status_q[tcpc_pkg::BIT_STOP];
   assign ovf      = count_en & (count_q == modulo_q);
   assign buffered = ctrl_q[0][tcpc_pkg::BIT_MS_HI];

   assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
   assign do_wr         = aw_q & w_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_ok = awaddr_q inside {tcpc_pkg::ADDR_STATUS, tcpc_pkg::ADDR_COUNT,
                  tcpc_pkg::ADDR_MODULO, tcpc_pkg::ADDR_CH0_CTRL, tcpc_pkg::ADDR_CH0_VAL,
                  tcpc_pkg::ADDR_CH1_CTRL, tcpc_pkg::ADDR_CH1_VAL};
   assign rd_ok = s_axi_araddr inside {tcpc_pkg::ADDR_STATUS, tcpc_pkg::ADDR_COUNT,
                  tcpc_pkg::ADDR_MODULO, tcpc_pkg::ADDR_CH0_CTRL, tcpc_pkg::ADDR_CH0_VAL,
                  tcpc_pkg::ADDR_CH1_CTRL, tcpc_pkg::ADDR_CH1_VAL};

   always_comb begin
      case (s_axi_araddr)
         tcpc_pkg::ADDR_STATUS:   rd_mux = {24'h000000, status_q};
         tcpc_pkg::ADDR_COUNT:    rd_mux = {16'h0000, count_q};
         tcpc_pkg::ADDR_MODULO:   rd_mux = {16'h0000, modulo_q};
         tcpc_pkg::ADDR_CH0_CTRL: rd_mux = {24'h000000, ctrl_q[0]};
         tcpc_pkg::ADDR_CH0_VAL:  rd_mux = {16'h0000, val_q[0]};
         tcpc_pkg::ADDR_CH1_CTRL: rd_mux = {24'h000000, ctrl_q[1]};
         tcpc_pkg::ADDR_CH1_VAL:  rd_mux = {16'h0000, val_q[1]};
         default:                 rd_mux = 32'h00000000;
      endcase
   end

   // Buffered mode: both channel registers feed channel 0, swapped each overflow.
   assign eff_val[0] = shadow_q[0];
   assign eff_val[1] = val_q[1];

   // A select flop rather than a value compare, so that rewriting the active register or
   // equal values in both registers cannot break the alternation.
   always_ff @(posedge aclk) begin
      if (!aresetn || !buffered) begin
         buf_sel_q <= 1'b0;
      end else if (ovf) begin
         buf_sel_q <= ~buf_sel_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
         end else if (do_wr) begin
            w_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= tcpc_pkg::RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= tcpc_pkg::RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
      end else begin
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? tcpc_pkg::RESP_OKAY : tcpc_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_ok ? tcpc_pkg::RESP_OKAY : tcpc_pkg::RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q  <= 16'h0000;
         modulo_q <= tcpc_pkg::MODULO_RESET;
         status_q <= 8'h00;
      end else begin
         if (do_wr && awaddr_q == tcpc_pkg::ADDR_COUNT && s_axi_wstrb[0]) begin
            count_q <= 16'h0000;
         end else if (ovf) begin
            count_q <= 16'h0000;
         end else if (count_en) begin
            count_q <= count_q + 16'h0001;
         end
         if (do_wr && awaddr_q == tcpc_pkg::ADDR_MODULO) begin
            modulo_q <= wdata_q[15:0];
         end
         if (ovf) begin
            status_q[tcpc_pkg::BIT_OVF_FLAG] <= 1'b1;
         end else if (do_wr && awaddr_q == tcpc_pkg::ADDR_STATUS &&
                      !wdata_q[tcpc_pkg::BIT_OVF_FLAG]) begin
            status_q[tcpc_pkg::BIT_OVF_FLAG] <= 1'b0;
         end
         if (do_wr && awaddr_q == tcpc_pkg::ADDR_STATUS) begin
            status_q[tcpc_pkg::BIT_STOP] <= wdata_q[tcpc_pkg::BIT_STOP];
         end
      end
   end

   // Two-stage synchroniser for the external pins.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= chan_pin_in;
         sync2_q <= sync1_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_ch
         localparam logic [7:0] CA = (gi == 0) ? tcpc_pkg::ADDR_CH0_CTRL :
                                                 tcpc_pkg::ADDR_CH1_CTRL;
         localparam logic [7:0] VA = (gi == 0) ? tcpc_pkg::ADDR_CH0_VAL :
                                                 tcpc_pkg::ADDR_CH1_VAL;
         assign cfg_wr[gi] = do_wr && awaddr_q == CA;
         assign cfg[gi] = '{ms_hi:    ctrl_q[gi][tcpc_pkg::BIT_MS_HI],
                            ms_lo:    ctrl_q[gi][tcpc_pkg::BIT_MS_LO],
                            els_hi:   ctrl_q[gi][tcpc_pkg::BIT_ELS_HI],
                            els_lo:   ctrl_q[gi][tcpc_pkg::BIT_ELS_LO],
                            tov:      ctrl_q[gi][tcpc_pkg::BIT_TOV],
                            max_duty: ctrl_q[gi][tcpc_pkg::BIT_MAX]};

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               ctrl_q[gi]   <= tcpc_pkg::CTRL_RESET;
               val_q[gi]    <= 16'h0000;
               shadow_q[gi] <= 16'h0000;
            end else begin
               if (cap_evt[gi]) begin
                  ctrl_q[gi][tcpc_pkg::BIT_CAP_FLAG] <= 1'b1;
               end else if (cfg_wr[gi] && !wdata_q[tcpc_pkg::BIT_CAP_FLAG]) begin
                  ctrl_q[gi][tcpc_pkg::BIT_CAP_FLAG] <= 1'b0;
               end
               if (cfg_wr[gi]) begin
                  ctrl_q[gi][5:0] <= wdata_q[5:0];
               end
               if (cap_evt[gi]) begin
                  val_q[gi] <= count_q;
               end else if (do_wr && awaddr_q == VA) begin
                  val_q[gi] <= wdata_q[15:0];
               end
               if (!buffered || gi != 0) begin
                  shadow_q[gi] <= val_q[gi];
               end else if (ovf) begin
                  shadow_q[gi] <= buf_sel_q ? val_q[0] : val_q[1];
               end
            end
         end

         tcpc_channel #(
            .BUFFER_OK (gi == 0)
         ) u_ch (
            .aclk     (aclk),
            .aresetn  (aresetn),
            .cfg      (cfg[gi]),
            .count    (count_q),
            .count_en (count_en),
            .ovf      (ovf),
            .cmp_val  (eff_val[gi]),
            .pin_sync (sync2_q[gi]),
            .cfg_wr   (cfg_wr[gi]),
            .cap_evt  (cap_evt[gi]),
            .pin_out  (chan_pin_out[gi]),
            .pin_oe   (chan_pin_oe[gi])
         );
      end
   endgenerate

   break_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (break_active && !(do_wr && awaddr_q == tcpc_pkg::ADDR_COUNT)) |=> $stable(count_q))
      else $error("counter moved during break");
   els_reset_a: assert property (@(posedge aclk)
      !aresetn |=> ctrl_q[0][3:2] == 2'b00 && ctrl_q[1][3:2] == 2'b00)
      else $error("edge bits not cleared by reset");
   ovf_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ovf && !(do_wr && awaddr_q == tcpc_pkg::ADDR_COUNT)) |=> count_q == 16'h0000)
      else $error("counter did not wrap at modulo");
endmodule : tcpc_top

// ===== tcpc_pin_model.sv
// External circuit on the two channel pins: drives a level unless the timer drives the pin.
`timescale 1ns/1ps
module tcpc_pin_model (
   input  wire logic [1:0] drive_lvl,
   input  wire logic [1:0] chan_pin_out,
   input  wire logic [1:0] chan_pin_oe,
   output logic      [1:0] pin_level
);
   // The wire follows the timer while it drives, otherwise the outside source.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pin_level[i] = chan_pin_oe[i] ? chan_pin_out[i] : drive_lvl[i];
      end
   end
endmodule : tcpc_pin_model

// ===== timer_channel_pin_control_test.sv
// Self-checking testbench of the timer channel pin control block.
`timescale 1ns/1ps
module timer_channel_pin_control_test;
   logic        aclk;
   logic        aresetn;
   logic        break_active;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [1:0]  drive_lvl, pin_level, pin_out, pin_oe;
   int          errors, n_checks;
   logic [31:0] rd, rd2;
   logic [1:0]  rsp;

   tcpc_top dut (
      .aclk(aclk), .aresetn(aresetn), .break_active(break_active),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .chan_pin_in(pin_level),
      .chan_pin_out(pin_out), .chan_pin_oe(pin_oe)
   );

   tcpc_pin_model partner (
      .drive_lvl(drive_lvl), .chan_pin_out(pin_out), .chan_pin_oe(pin_oe),
      .pin_level(pin_level)
   );

   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while ((awvalid && !awready) || (wvalid && !wready));
      bready <= 1'b1;
      do @(posedge aclk); while (!bvalid);
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      rready  <= 1'b1;
      do @(posedge aclk); while (!rvalid);
      d   = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : rd_reg

   task automatic test_reset_state();
      rd_reg(tcpc_pkg::ADDR_CH0_CTRL, rd);
      chk(rd, 32'h0000_0000);
      rd_reg(tcpc_pkg::ADDR_MODULO, rd);
      chk(rd, {16'h0000, tcpc_pkg::MODULO_RESET});
      chk({30'h0, pin_oe}, 32'h0);
      chk({31'h0, pin_out[0]}, 32'h1);
      rd_reg(8'h1C, rd);
      chk(rd, 32'h0000_0000);
      chk({30'h0, rsp}, {30'h0, tcpc_pkg::RESP_SLVERR});
      wr(8'h1C, 32'h0000_00FF);
      chk({30'h0, rsp}, {30'h0, tcpc_pkg::RESP_SLVERR});
      wr(tcpc_pkg::ADDR_CH0_CTRL, 32'h0000_0010);
      repeat (2) @(posedge aclk);
      chk({30'h0, pin_out[0], pin_oe[0]}, 32'h0);
      $display("test reset_state done");
   endtask : test_reset_state

   task automatic test_capture();
      for (int c = 1; c < 4; c++) begin
         drive_lvl <= 2'b00;
         repeat (3) @(posedge aclk);
         wr(tcpc_pkg::ADDR_CH1_CTRL, 32'(c) << 2);
         drive_lvl <= 2'b10;
         repeat (6) @(posedge aclk);
         rd_reg(tcpc_pkg::ADDR_CH1_CTRL, rd);
         chk({31'h0, rd[7]}, {31'h0, c != 2});
         chk({31'h0, pin_oe[1]}, 32'h0);
         wr(tcpc_pkg::ADDR_CH1_CTRL, 32'(c) << 2);
         drive_lvl <= 2'b00;
         repeat (6) @(posedge aclk);
         rd_reg(tcpc_pkg::ADDR_CH1_CTRL, rd);
         chk({31'h0, rd[7]}, {31'h0, c != 1});
         wr(tcpc_pkg::ADDR_CH1_CTRL, 32'h0000_0000);
      end
      $display("test capture done");
   endtask : test_capture

   task automatic test_compare();
      wr(tcpc_pkg::ADDR_MODULO, 32'h0000_001F);
      // Restart the count, which may already stand above the new modulo.
      wr(tcpc_pkg::ADDR_COUNT, 32'h0000_0000);
      wr(tcpc_pkg::ADDR_CH1_VAL, 32'h0000_0010);
      wr(tcpc_pkg::ADDR_CH1_CTRL, 32'h0000_0018);
      repeat (70) @(posedge aclk);
      chk({30'h0, pin_out[1], pin_oe[1]}, 32'h1);
      wr(tcpc_pkg::ADDR_CH1_CTRL, 32'h0000_001C);
      repeat (70) @(posedge aclk);
      chk({30'h0, pin_out[1], pin_oe[1]}, 32'h3);
      wr(tcpc_pkg::ADDR_CH1_CTRL, 32'h0000_0014);
      repeat (70) @(posedge aclk);
      rd = {31'h0, pin_out[1]};
      repeat (32) @(posedge aclk);
      chk({31'h0, pin_out[1]}, rd ^ 32'h1);
      $display("test compare done");
   endtask : test_compare

   task automatic test_overflow();
      wr(tcpc_pkg::ADDR_CH1_VAL, 32'h0000_001F);
      wr(tcpc_pkg::ADDR_CH1_CTRL, 32'h0000_001A);
      repeat (70) @(posedge aclk);
      rd = {31'h0, pin_out[1]};
      repeat (32) @(posedge aclk);
      chk({31'h0, pin_out[1]}, rd ^ 32'h1);
      repeat (32) @(posedge aclk);
      chk({31'h0, pin_out[1]}, rd);
      wr(tcpc_pkg::ADDR_CH1_CTRL, 32'h0000_001B);
      repeat (40) @(posedge aclk);
      rd2 = 32'h1;
      repeat (64) begin
         @(posedge aclk);
         rd2 = rd2 & {31'h0, pin_out[1]};
      end
      chk(rd2, 32'h1);
      $display("test overflow done");
   endtask : test_overflow

   task automatic test_buffered();
      wr(tcpc_pkg::ADDR_CH0_VAL, 32'h0000_0008);
      wr(tcpc_pkg::ADDR_CH1_VAL, 32'h0000_0018);
      wr(tcpc_pkg::ADDR_CH0_CTRL, 32'h0000_002A);
      wr(tcpc_pkg::ADDR_CH1_CTRL, 32'h0000_0028);
      chk({31'h0, pin_oe[1]}, 32'h0);
      repeat (100) @(posedge aclk);
      chk({31'h0, pin_oe[0]}, 32'h1);
      // High for value plus one cycles per period, the periods using each value in turn.
      rd2 = 32'h0;
      repeat (64) begin
         @(posedge aclk);
         rd2 = rd2 + {31'h0, pin_out[0]};
      end
      chk(rd2, 32'h0000_0008 + 32'h0000_0018 + 32'h0000_0002);
      $display("test buffered done");
   endtask : test_buffered

   task automatic test_break();
      break_active <= 1'b1;
      @(posedge aclk);
      rd_reg(tcpc_pkg::ADDR_COUNT, rd);
      repeat (10) @(posedge aclk);
      rd_reg(tcpc_pkg::ADDR_COUNT, rd2);
      chk(rd2, rd);
      break_active <= 1'b0;
      repeat (10) @(posedge aclk);
      rd_reg(tcpc_pkg::ADDR_COUNT, rd2);
      chk({31'h0, rd2 != rd}, 32'h1);
      $display("test break done");
   endtask : test_break

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (20000) @(posedge aclk);
      errors++;
      $display("ERROR at %0t: watchdog expired", $time);
      print_verdict();
   end

   initial begin
      errors = 0;
      n_checks = 0;
      aresetn = 1'b0;
      break_active = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      drive_lvl = 2'b00;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      test_reset_state();
      test_capture();
      test_compare();
      test_overflow();
      test_buffered();
      test_break();
      print_verdict();
   end
endmodule : timer_channel_pin_control_test
